// ---- hw/console_pkg.sv ----
// Shared constants and carrier types for the front-panel console control
package console_pkg;

  // ----------------------------------------------------------------
  // Timing and widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned STEP_RATE_MIN = 1;
  localparam int unsigned STEP_RATE_MAX = 1000;
  localparam int unsigned KNOB_W        = 10;
  localparam int unsigned WORD_W        = 16;

  // ----------------------------------------------------------------
  // Addresses, increments, reset values, field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] PSW_SAVE_ADDR = 16'h0024;
  localparam logic [15:0] LC_INCREMENT  = 16'h0002;
  localparam logic [15:0] LC_RESET      = 16'h0000;
  localparam logic [15:0] DISPLAY_RESET = 16'h0000;
  // Status bit 0 is numbered from the most significant end
  localparam int unsigned PSW_WAIT_BIT  = 15;
  // Location counter bit 31 is the least significant bit
  localparam int unsigned LC_EVEN_BIT   = 0;

  // ----------------------------------------------------------------
  // Display selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] VIEW_INS        = 4'h0;
  localparam logic [3:0] VIEW_PSW        = 4'h1;
  localparam logic [3:0] VIEW_PAIR_FIRST = 4'h2;
  localparam logic [3:0] VIEW_PAIR_LAST  = 4'h9;
  localparam logic [3:0] VIEW_OFF        = 4'ha;

  // ----------------------------------------------------------------
  // Mode selector encoding
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    variable_speed_mode,
    run_mode,
    address_entry_mode,
    memory_read_mode,
    memory_write_mode,
    halt_mode
  } mode_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        mode;
    logic [3:0]        view;
    logic              floating_register_select;
    logic              speed_single;
    logic [KNOB_W-1:0] speed_knob;
    logic [15:0]       switches;
    logic              execute_pushbutton;
  } panel_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic        run;
    logic        step;
    logic        console_halt;
    logic        lc_load;
    logic [15:0] lc_value;
    logic        status_load;
    logic [15:0] status_value;
  } core_cmd_type;

  typedef struct packed {
    logic [15:0] d1;
    logic [15:0] d2;
  } display_type;

endpackage

// ---- hw/step_rate_timer.sv ----
// Tick generator setting the variable-speed instruction rate from the knob
`timescale 1ns/1ps
module step_rate_timer
  import console_pkg::*;
#(
  parameter int unsigned CLOCK_HZ = CLK_HZ,
  parameter int unsigned RATE_LO  = STEP_RATE_MIN,
  parameter int unsigned RATE_HI  = STEP_RATE_MAX,
  parameter int unsigned K_W      = KNOB_W
) (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  // Control
  input  wire logic           enable,
  input  wire logic [K_W-1:0] knob,
  // Rate tick
  output logic                tick
);

  localparam int unsigned ACC_W = $clog2(CLOCK_HZ + RATE_HI) + 1;

  if (RATE_LO < 1 || RATE_HI < RATE_LO || RATE_HI >= CLOCK_HZ) begin : g_chk
    $error("step_rate_timer: rate limits not servable");
  end

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] rate;
  logic [ACC_W-1:0] sum;

  // Knob saturates at both ends of the range
  always_comb begin
    if (ACC_W'(knob) < ACC_W'(RATE_LO)) begin
      rate = ACC_W'(RATE_LO);
    end else if (ACC_W'(knob) > ACC_W'(RATE_HI)) begin
      rate = ACC_W'(RATE_HI);
    end else begin
      rate = ACC_W'(knob);
    end
    sum = acc_q + rate;
  end

  // Phase accumulator: exact average rate, no divider needed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      tick  <= 1'b0;
    end else if (clk_en) begin
      if (!enable) begin
        acc_q <= '0;
        tick  <= 1'b0;
      end else if (sum >= ACC_W'(CLOCK_HZ)) begin
        acc_q <= sum - ACC_W'(CLOCK_HZ);
        tick  <= 1'b1;
      end else begin
        acc_q <= sum;
        tick  <= 1'b0;
      end
    end
  end

endmodule

// ---- hw/front_panel_console_control.sv ----
// Front-panel console control: mode selector, execute button and display views
//
// Contract
// - Every execute press acts according to the mode selector position, except in normal run, where only a halt press acts.
// - Variable speed at single position runs one instruction per press.
// - Variable speed between limits steps continuously, 1 to 1000 per second.
// - Single or variable stepping refreshes both displays after each instruction, except in off view.
// - Normal run leaves displays to the program; otherwise they hold.
// - Address entry copies switches to location counter, least bit cleared.
// - After address entry with status view, displays show the new status word.
// - Memory read shows address and data, then adds 2 to counter.
// - Memory write stores switches, shows address and data, adds 2.
// - Halt press stops execution into a noninterruptible halt.
// - Address entry, memory read and write also leave noninterruptible halt.
// - Wait lamp lit when halted, between steps, or program wait bit set.
// - Program wait stays interruptible; console halt blocks interrupts.
// - Halt press drives displays from the view selector positions.
// - Next-instruction view fetches two halfwords at the location counter.
// - Status view shows status and condition code, then location counter.
// - Pair view without floating select shows even then odd register.
// - Pair view with floating select shows upper then lower floating half.
// - Off view drives nothing; program-written values stay visible.
// - After power-up, program status loads from save area at 0024.
`timescale 1ns/1ps
module front_panel_console_control
  import console_pkg::*;
#(
  parameter int unsigned CLOCK_HZ = CLK_HZ,
  parameter int unsigned RATE_LO  = STEP_RATE_MIN,
  parameter int unsigned RATE_HI  = STEP_RATE_MAX
) (
  // Clock, reset, enable
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Operator panel (asynchronous pins)
  input  wire panel_type    panel,
  // Operator lamps and displays
  output display_type       display_q,
  output logic              wait_lamp_q,
  // Core control and status word
  output core_cmd_type      cmd_q,
  input  wire logic         step_done,
  input  wire logic [15:0]  psw_status,
  input  wire logic [15:0]  psw_lc,
  // Core memory port
  output mem_req_type       mem_q,
  input  wire logic         mem_ack,
  input  wire logic [15:0]  mem_rdata,
  // Core register file views
  output logic [2:0]        reg_pair_q,
  input  wire logic [15:0]  gr_even,
  input  wire logic [15:0]  gr_odd,
  input  wire logic [31:0]  fr_data,
  // Program output to the display panel
  input  wire logic         prog_disp_we,
  input  wire display_type  prog_disp
);

  if (RATE_LO < 1 || RATE_HI < RATE_LO || RATE_HI >= CLOCK_HZ) begin : g_chk
    $error("front_panel_console_control: bad rate limits");
  end

  typedef enum logic [3:0] {
    st_boot,
    st_boot_wait,
    st_idle,
    st_mem_wait,
    st_step_wait,
    st_view,
    st_pair,
    st_fetch1,
    st_fetch2,
    st_run
  } state_type;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_pair_view(input logic [3:0] v);
    return (v >= VIEW_PAIR_FIRST) && (v <= VIEW_PAIR_LAST);
  endfunction

  function automatic logic [15:0] next_even(input logic [15:0] a);
    logic [15:0] n;
    n = a + LC_INCREMENT;
    n[LC_EVEN_BIT] = 1'b0;
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Panel synchroniser and press detection
  // ----------------------------------------------------------------
  panel_type   pan_meta_q;
  panel_type   pan_q;
  state_type   state_q;
  logic        exec_prev_q;
  logic        press_edge;
  logic        press_pend_q;
  logic        press;

  // Whole panel passes two flops before any decode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pan_meta_q <= '0;
      pan_q      <= '0;
    end else if (clk_en) begin
      pan_meta_q <= panel;
      pan_q      <= pan_meta_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exec_prev_q <= 1'b0;
    end else if (clk_en) begin
      exec_prev_q <= pan_q.execute_pushbutton;
    end
  end

  // Button is latching-free momentary: act once per rising edge
  assign press_edge = pan_q.execute_pushbutton & ~exec_prev_q;

  // ----------------------------------------------------------------
  // Press held over a busy sequence
  // ----------------------------------------------------------------
  // A halt pressed mid-step must still stop the stream, so it waits here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      press_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (press_edge && state_q != st_idle && state_q != st_run) begin
        press_pend_q <= 1'b1;
      end else if (state_q == st_idle || state_q == st_run) begin
        press_pend_q <= 1'b0;
      end
    end
  end

  assign press = press_edge | press_pend_q;

  // ----------------------------------------------------------------
  // Variable-rate ticks
  // ----------------------------------------------------------------
  logic        variable_speed_mode_cont_q;
  logic        variable_speed_mode_session_q;
  logic        tick;
  logic [15:0] lc_q;

  step_rate_timer #(
    .CLOCK_HZ (CLOCK_HZ),
    .RATE_LO  (RATE_LO),
    .RATE_HI  (RATE_HI),
    .K_W      (KNOB_W)
  ) u_rate (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .enable (variable_speed_mode_cont_q),
    .knob   (pan_q.speed_knob),
    .tick   (tick)
  );

  // ----------------------------------------------------------------
  // Console sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q            <= st_boot;
      display_q          <= {DISPLAY_RESET, DISPLAY_RESET};
      lc_q               <= LC_RESET;
      reg_pair_q         <= 3'h0;
      mem_q              <= '0;
      cmd_q              <= '0;
      cmd_q.console_halt <= 1'b1;
      variable_speed_mode_cont_q        <= 1'b0;
      variable_speed_mode_session_q     <= 1'b0;
    end else if (clk_en) begin
      cmd_q.step        <= 1'b0;
      cmd_q.lc_load     <= 1'b0;
      cmd_q.status_load <= 1'b0;
      unique case (state_q)
        st_boot: begin
          mem_q <= '{req: 1'b1, we: 1'b0, addr: PSW_SAVE_ADDR, wdata: 16'h0000};
          state_q <= st_boot_wait;
        end
        st_boot_wait: begin
          if (mem_ack) begin
            mem_q.req          <= 1'b0;
            cmd_q.status_load  <= 1'b1;
            cmd_q.status_value <= mem_rdata;
            state_q            <= st_idle;
          end
        end
        st_idle: begin
          if (press) begin
            case (mode_type'(pan_q.mode))
              variable_speed_mode: begin
                cmd_q.console_halt <= 1'b0;
                variable_speed_mode_session_q     <= 1'b1;
                if (pan_q.speed_single) begin
                  cmd_q.step <= 1'b1;
                  state_q    <= st_step_wait;
                end else begin
                  variable_speed_mode_cont_q <= 1'b1;
                end
              end
              run_mode: begin
                cmd_q.console_halt <= 1'b0;
                cmd_q.run          <= 1'b1;
                variable_speed_mode_cont_q        <= 1'b0;
                variable_speed_mode_session_q     <= 1'b0;
                state_q            <= st_run;
              end
              address_entry_mode: begin
                lc_q               <= {pan_q.switches[15:1], 1'b0};
                cmd_q.lc_load      <= 1'b1;
                cmd_q.lc_value     <= {pan_q.switches[15:1], 1'b0};
                cmd_q.console_halt <= 1'b1;
                variable_speed_mode_cont_q        <= 1'b0;
                variable_speed_mode_session_q     <= 1'b0;
                if (pan_q.view == VIEW_PSW) begin
                  state_q <= st_view;
                end
              end
              memory_read_mode, memory_write_mode: begin
                mem_q.req          <= 1'b1;
                mem_q.we           <= (pan_q.mode == memory_write_mode);
                mem_q.addr         <= lc_q;
                mem_q.wdata        <= pan_q.switches;
                cmd_q.console_halt <= 1'b1;
                variable_speed_mode_cont_q        <= 1'b0;
                variable_speed_mode_session_q     <= 1'b0;
                state_q            <= st_mem_wait;
              end
              halt_mode: begin
                cmd_q.console_halt <= 1'b1;
                variable_speed_mode_cont_q        <= 1'b0;
                variable_speed_mode_session_q     <= 1'b0;
                state_q            <= st_view;
              end
              default: ;
            endcase
          end else if (variable_speed_mode_cont_q) begin
            // Leaving the mode or returning to single stops the stream
            if (pan_q.mode != variable_speed_mode || pan_q.speed_single) begin
              variable_speed_mode_cont_q <= 1'b0;
            end else if (tick) begin
              cmd_q.step <= 1'b1;
              state_q    <= st_step_wait;
            end
          end
        end
        st_mem_wait: begin
          if (mem_ack) begin
            mem_q.req    <= 1'b0;
            display_q.d1 <= mem_q.addr;
            display_q.d2 <= mem_q.we ? mem_q.wdata : mem_rdata;
            lc_q         <= next_even(lc_q);
            cmd_q.lc_load  <= 1'b1;
            cmd_q.lc_value <= next_even(lc_q);
            state_q      <= st_idle;
          end
        end
        st_step_wait: begin
          if (step_done) begin
            lc_q    <= psw_lc;
            state_q <= st_view;
          end
        end
        st_view: begin
          if (pan_q.view == VIEW_INS) begin
            mem_q   <= '{req: 1'b1, we: 1'b0, addr: lc_q, wdata: 16'h0000};
            state_q <= st_fetch1;
          end else if (pan_q.view == VIEW_PSW) begin
            display_q <= '{d1: psw_status, d2: lc_q};
            state_q   <= st_idle;
          end else if (is_pair_view(pan_q.view)) begin
            reg_pair_q <= 3'(pan_q.view - VIEW_PAIR_FIRST);
            state_q    <= st_pair;
          end else begin
            state_q <= st_idle;
          end
        end
        st_pair: begin
          // Index settled last cycle, so register data is valid now
          if (pan_q.floating_register_select) begin
            display_q <= '{d1: fr_data[31:16], d2: fr_data[15:0]};
          end else begin
            display_q <= '{d1: gr_even, d2: gr_odd};
          end
          state_q <= st_idle;
        end
        st_fetch1: begin
          if (mem_ack) begin
            display_q.d1 <= mem_rdata;
            mem_q.addr   <= lc_q + LC_INCREMENT;
            state_q      <= st_fetch2;
          end
        end
        st_fetch2: begin
          if (mem_ack) begin
            mem_q.req    <= 1'b0;
            display_q.d2 <= mem_rdata;
            state_q      <= st_idle;
          end
        end
        st_run: begin
          if (prog_disp_we) begin
            display_q <= prog_disp;
          end
          if (press && pan_q.mode == halt_mode) begin
            cmd_q.run          <= 1'b0;
            cmd_q.console_halt <= 1'b1;
            lc_q               <= psw_lc;
            state_q            <= st_view;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wait lamp
  // ----------------------------------------------------------------
  // Program wait never feeds console_halt, so it stays interruptible
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_lamp_q <= 1'b1;
    end else if (clk_en) begin
      wait_lamp_q <= cmd_q.console_halt
                   | (variable_speed_mode_session_q && state_q != st_step_wait)
                   | psw_status[PSW_WAIT_BIT];
    end
  end

endmodule

// ---- verif/front_panel_console_control_assertions.sv ----
// Concurrent checks on the console control ports
`timescale 1ns/1ps
module front_panel_console_control_assertions
  import console_pkg::*;
(
  // Clock and reset
  input wire logic         mclk,
  input wire logic         rst_n,
  // Observed ports
  input wire core_cmd_type cmd_q,
  input wire mem_req_type  mem_q,
  input wire logic         mem_ack,
  input wire logic [15:0]  mem_rdata,
  input wire display_type  display_q,
  input wire logic         wait_lamp_q,
  input wire logic [15:0]  psw_status,
  input wire logic         prog_disp_we,
  input wire display_type  prog_disp
);
  logic booted_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      booted_q <= 1'b0;
    else if (cmd_q.status_load)
      booted_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  boot_read_a: assert property (mem_q.req && !booted_q |->
    !mem_q.we && mem_q.addr == 16'h0024) else $error("boot read address wrong");
  status_load_a: assert property (mem_ack && !booted_q |=>
    cmd_q.status_load && cmd_q.status_value == $past(mem_rdata))
    else $error("status not loaded from boot read");
  lc_even_a: assert property (cmd_q.lc_load |-> !cmd_q.lc_value[0])
    else $error("odd location counter loaded");
  lc_halt_a: assert property (cmd_q.lc_load |-> cmd_q.console_halt)
    else $error("counter load while not halted");
  mem_hold_a: assert property (mem_q.req && !mem_ack |=>
    mem_q.req && $stable(mem_q.addr) && $stable(mem_q.we))
    else $error("memory request dropped early");
  write_show_a: assert property (mem_q.req && mem_q.we && mem_ack |=>
    display_q.d1 == $past(mem_q.addr) && display_q.d2 == $past(mem_q.wdata) &&
    cmd_q.lc_load && cmd_q.lc_value == $past(mem_q.addr) + 16'h0002)
    else $error("write display or increment wrong");
  step_pulse_a: assert property ($rose(cmd_q.step) |=> !cmd_q.step)
    else $error("step longer than one cycle");
  run_open_a: assert property (cmd_q.run |-> !cmd_q.console_halt)
    else $error("halt held during run");
  halt_lamp_a: assert property (cmd_q.console_halt |=> wait_lamp_q)
    else $error("lamp dark while halted");
  prog_wait_a: assert property (psw_status[15] |=> wait_lamp_q)
    else $error("lamp dark in program wait");
  prog_show_a: assert property (cmd_q.run && prog_disp_we |=>
    display_q == $past(prog_disp)) else $error("program display write lost");

  cover property (cmd_q.step);
  cover property (mem_q.we && mem_ack);
  cover property (cmd_q.run && prog_disp_we);
endmodule

bind front_panel_console_control front_panel_console_control_assertions i_chk (
  .mclk(mclk), .rst_n(rst_n), .cmd_q(cmd_q), .mem_q(mem_q), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .display_q(display_q), .wait_lamp_q(wait_lamp_q),
  .psw_status(psw_status), .prog_disp_we(prog_disp_we), .prog_disp(prog_disp));

// ---- verif/core_model.sv ----
// Behavioural core: memory, location counter, stepping and register views
`timescale 1ns/1ps
module core_model
  import console_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // From the console
  input  wire core_cmd_type cmd_q,
  input  wire mem_req_type  mem_q,
  input  wire logic [2:0]   reg_pair_q,
  // To the console
  output logic              mem_ack,
  output logic [15:0]       mem_rdata,
  output logic              step_done,
  output logic [15:0]       psw_lc,
  output logic [15:0]       gr_even,
  output logic [15:0]       gr_odd,
  output logic [31:0]       fr_data
);
  logic [15:0] mem [256];
  logic [1:0]  wait_q;
  logic        slow_q;
  logic [1:0]  busy_q;

  initial for (int i = 0; i < 256; i++) mem[i] = 16'ha500 ^ 16'(2 * i);

  // Data shown only with ack; otherwise inverted so stale reads show
  assign mem_rdata = mem_ack ? mem[mem_q.addr[8:1]] : ~mem[mem_q.addr[8:1]];
  assign gr_even   = 16'h1000 + {12'h000, reg_pair_q, 1'b0};
  assign gr_odd    = gr_even + 16'h0001;
  assign fr_data   = {16'hf000 + {13'h0, reg_pair_q}, 16'h0f00 + {13'h0, reg_pair_q}};

  // Acks alternate fast and slow
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_q <= 2'd0;
      slow_q <= 1'b0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_q <= 2'd0;
      slow_q <= !slow_q;
      if (mem_q.we)
        mem[mem_q.addr[8:1]] <= mem_q.wdata;
    end else if (mem_q.req) begin
      wait_q <= wait_q + 2'd1;
      mem_ack <= (wait_q == (slow_q ? 2'd3 : 2'd0));
    end
  end

  // Counter moves a cycle before step_done so the console reads it settled
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psw_lc <= 16'h0000;
      busy_q <= 2'd0;
      step_done <= 1'b0;
    end else begin
      step_done <= (busy_q == 2'd1);
      if (cmd_q.step)
        busy_q <= 2'd3;
      else if (busy_q != 2'd0)
        busy_q <= busy_q - 2'd1;
      if (cmd_q.lc_load)
        psw_lc <= cmd_q.lc_value;
      else if (busy_q == 2'd2)
        psw_lc <= psw_lc + 16'h0002;
    end
  end
endmodule

// ---- verif/front_panel_console_control_bench.sv ----
// Self-checking bench for the front-panel console control
`timescale 1ns/1ps
module front_panel_console_control_bench;
  import console_pkg::*;

  logic         mclk, rst_n, mem_ack, step_done, prog_disp_we, wait_lamp_q, clk_en;
  panel_type    panel;
  display_type  display_q, prog_disp, snap;
  core_cmd_type cmd_q;
  mem_req_type  mem_q;
  logic [15:0]  psw_status, psw_lc, mem_rdata, gr_even, gr_odd;
  logic [31:0]  fr_data;
  logic [2:0]   reg_pair_q;
  int           fails, samples_checked, steps, cycles;

  front_panel_console_control #(.CLOCK_HZ(10000)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .panel(panel), .display_q(display_q),
    .wait_lamp_q(wait_lamp_q), .cmd_q(cmd_q), .step_done(step_done),
    .psw_status(psw_status), .psw_lc(psw_lc), .mem_q(mem_q), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .reg_pair_q(reg_pair_q), .gr_even(gr_even), .gr_odd(gr_odd),
    .fr_data(fr_data), .prog_disp_we(prog_disp_we), .prog_disp(prog_disp));

  core_model i_core (
    .mclk(mclk), .rst_n(rst_n), .cmd_q(cmd_q), .mem_q(mem_q), .reg_pair_q(reg_pair_q),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .step_done(step_done), .psw_lc(psw_lc),
    .gr_even(gr_even), .gr_odd(gr_odd), .fr_data(fr_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Room for sync, fetch pair and slow acks before looking
  task automatic press(input mode_type m);
    panel.mode = m;
    panel.execute_pushbutton = 1'b1;
    tick(5);
    panel.execute_pushbutton = 1'b0;
    tick(40);
  endtask

  task automatic enter(input logic [15:0] a);
    panel.switches = a;
    press(address_entry_mode);
  endtask

  task automatic put(input logic [15:0] d);
    panel.switches = d;
    press(memory_write_mode);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic boot_check();
    int n;
    n = 0;
    while (cmd_q.status_load !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(cmd_q.status_value, 16'ha524);
  endtask

  task automatic address_and_write();
    panel.view = 4'h1;
    enter(16'h0123);
    check(psw_lc, 16'h0122);
    check(display_q, {16'h0c30, 16'h0122});
    check(wait_lamp_q, 1'b1);
    put(16'hbeef);
    check(display_q, {16'h0122, 16'hbeef});
    put(16'h1234);
    check(display_q, {16'h0124, 16'h1234});
    enter(16'hfffe);
    put(16'h0055);
    check(display_q, {16'hfffe, 16'h0055});
    check(psw_lc, 16'h0000);
  endtask

  task automatic read_back();
    enter(16'h0122);
    press(memory_read_mode);
    check(display_q, {16'h0122, 16'hbeef});
    press(memory_read_mode);
    check(display_q, {16'h0124, 16'h1234});
    check(psw_lc, 16'h0126);
    check(cmd_q.console_halt, 1'b1);
  endtask

  task automatic halt_views();
    enter(16'h0122);
    for (int v = 0; v < 8; v++) begin
      for (int f = 0; f < 2; f++) begin
        panel.view = 4'(v + 2);
        panel.floating_register_select = f[0];
        press(halt_mode);
        if (f == 1)
          check(display_q, {16'(16'hf000 + v), 16'(16'h0f00 + v)});
        else
          check(display_q, {16'(16'h1000 + 2 * v), 16'(16'h1001 + 2 * v)});
      end
    end
    panel.view = 4'ha;
    press(halt_mode);
    check(display_q, {16'hf007, 16'h0f07});
    panel.view = 4'h0;
    press(halt_mode);
    check(display_q, {16'hbeef, 16'h1234});
    panel.view = 4'h1;
    press(halt_mode);
    check(display_q, {16'h0c30, 16'h0122});
  endtask

  task automatic variable_speed();
    panel.view = 4'h1;
    panel.speed_single = 1'b1;
    steps = 0;
    press(variable_speed_mode);
    check(steps, 1);
    check(display_q, {16'h0c30, 16'h0124});
    check(wait_lamp_q, 1'b1);
    panel.speed_single = 1'b0;
    panel.speed_knob = 10'd1000;
    steps = 0;
    press(variable_speed_mode);
    tick(200);
    press(halt_mode);
    check(32'(steps >= 15 && steps <= 35), 1);
  endtask

  task automatic run_and_halt();
    snap = display_q;
    press(run_mode);
    check(cmd_q.run, 1'b1);
    check(display_q, snap);
    check(wait_lamp_q, 1'b0);
    prog_disp = {16'haaaa, 16'h5555};
    prog_disp_we = 1'b1;
    tick(1);
    prog_disp_we = 1'b0;
    tick(2);
    check(display_q, {16'haaaa, 16'h5555});
    psw_status = 16'h8c30;
    tick(3);
    check(wait_lamp_q, 1'b1);
    psw_status = 16'h0c30;
    press(halt_mode);
    check(cmd_q.run, 1'b0);
    check(cmd_q.console_halt, 1'b1);
    clk_en = 1'b0;
    press(run_mode);
    check(cmd_q.run, 1'b0);
    clk_en = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cmd_q.step === 1'b1)
      steps++;
    if (cycles == 8000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    panel = '0;
    psw_status = 16'h0c30;
    prog_disp_we = 1'b0;
    prog_disp = '0;
    repeat (3) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    boot_check();
    address_and_write();
    read_back();
    halt_views();
    variable_speed();
    run_and_halt();
    report_and_stop();
  end
endmodule
